// ===== ldc_pkg.sv
// Package for the LCD driver control register bank.
// Assumes one system clock and an 8-bit register port at the top level.
package ldc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 8;
    localparam int BLINK_W     = 6;
    localparam int CONTRAST_W  = 5;
    localparam int MAP_W       = 8;
    localparam int CLKSEL_W    = 2;
    localparam int MODE_W      = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MAIN     = 16'h2400;
    localparam logic [ADDR_W-1:0] OFS_BLINK23  = 16'h2401;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY22 = 16'h2402;
    localparam logic [ADDR_W-1:0] OFS_SEGMAP   = 16'h2405;
    localparam logic [ADDR_W-1:0] OFS_CONTRAST = 16'h240D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE   = 7;
    localparam int BIT_ALLCOM   = 3;
    localparam int BIT_BATTERY  = 7;
    localparam int LSB_MODE     = 4;
    localparam int LSB_CLKSEL   = 0;
    localparam int LSB_BLINK    = 0;
    localparam int LSB_CONTRAST = 0;

    // ------------------------------------------------------------
    // Reset values and analog figures
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

    // Writable bits of each register but the segment map (all bits writable); other bits read as zero
    localparam logic [DATA_W-1:0] MASK_MAIN     = 8'hFB;
    localparam logic [DATA_W-1:0] MASK_BLINK    = 8'h3F;
    localparam logic [DATA_W-1:0] MASK_SUPPLY   = 8'hBF;
    localparam logic [DATA_W-1:0] MASK_CONTRAST = 8'h1F;
    localparam real  VDRIVE_BASE_V = 2.65;
    localparam real  VDRIVE_SPAN_V = 2.65;
    localparam int   CONTRAST_FULL = 31;

    // Register port carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ldc_req_t;

    // Analog-side control carrier
    typedef struct packed {
        logic                  bias_ground;
        logic                  supply_from_battery;
        logic [CONTRAST_W-1:0] contrast_code;
        logic [CLKSEL_W-1:0]   frame_clock_select;
        logic [MODE_W-1:0]     bias_mode;
    } ldc_analog_t;

endpackage : ldc_pkg

// ===== ldc_lcd_driver_control.sv
// LCD driver control registers and pin-role steering.
// Assumes a register master on the same clock with one-cycle strobes,
// and analog bias/DAC circuits that take the decoded controls below.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

//
// Function
// - All-common turns mapped shared pins into commons
// - Battery select feeds panel supply from battery
// - Two six-bit blink maps, pins 23, 22
// - Blink bit 5 is common 5, bit 0 common 0
// - Contrast code sets drive voltage 2.65 V scale
// - Display disable grounds bias nodes and mapped pins
// - Map bit selects LCD function for shared pin
module ldc_lcd_driver_control
    import ldc_pkg::*;
#(
    parameter int N_MAP = 8                    // Segment map width
) (
    input  wire logic                     clk,          // 20 MHz clock
    input  wire logic                     rst,          // Async reset, high
    input  wire ldc_pkg::ldc_req_t        req,          // Register request
    output logic [ldc_pkg::DATA_W-1:0]    rdata,        // Read data, +1 cycle
    output ldc_pkg::ldc_analog_t          analog,       // Bias/DAC controls
    output logic [N_MAP-1:0]              pin_lcd_mode, // Pin in LCD role
    output logic [N_MAP-1:0]              pin_as_common,// Mapped pin is common
    output logic [N_MAP-1:0]              pin_force_gnd,// Pin held at ground
    output logic [ldc_pkg::BLINK_W-1:0]   blink23,      // Blink, pin 23
    output logic [ldc_pkg::BLINK_W-1:0]   blink22       // Blink, pin 22
);
    import ldc_pkg::*;

    initial begin
        if (N_MAP != MAP_W) begin
            $error("N_MAP must equal the map register width");
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] main_r;
    logic [DATA_W-1:0] blink23_r;
    logic [DATA_W-1:0] supply22_r;
    logic [DATA_W-1:0] segmap_r;
    logic [DATA_W-1:0] contrast_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    wire sel_main     = (req.addr == OFS_MAIN);
    wire sel_blink23  = (req.addr == OFS_BLINK23);
    wire sel_supply22 = (req.addr == OFS_SUPPLY22);
    wire sel_segmap   = (req.addr == OFS_SEGMAP);
    wire sel_contrast = (req.addr == OFS_CONTRAST);

    // Unused bit positions are dropped at write so they read as zero
    wire [DATA_W-1:0] main_mask     = MASK_MAIN;
    wire [DATA_W-1:0] blink_mask    = MASK_BLINK;
    wire [DATA_W-1:0] supply_mask   = MASK_SUPPLY;
    wire [DATA_W-1:0] contrast_mask = MASK_CONTRAST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_r     <= RST_BYTE;
            blink23_r  <= RST_BYTE;
            supply22_r <= RST_BYTE;
            segmap_r   <= RST_BYTE;
            contrast_r <= RST_BYTE;
        end else if (req.wr) begin
            if (sel_main)     main_r     <= req.wdata & main_mask;
            if (sel_blink23)  blink23_r  <= req.wdata & blink_mask;
            if (sel_supply22) supply22_r <= req.wdata & supply_mask;
            if (sel_segmap)   segmap_r   <= req.wdata;
            if (sel_contrast) contrast_r <= req.wdata & contrast_mask;
        end
    end

    // ------------------------------------------------------------
    // Read path; unmapped addresses read zero
    // ------------------------------------------------------------
    assign rdata_nxt = !req.rd      ? RST_BYTE   :
                       sel_main     ? main_r     :
                       sel_blink23  ? blink23_r  :
                       sel_supply22 ? supply22_r :
                       sel_segmap   ? segmap_r   :
                       sel_contrast ? contrast_r : RST_BYTE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= RST_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata = rdata_r;

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    wire display_enable    = main_r[BIT_ENABLE];
    wire all_common_select = main_r[BIT_ALLCOM];
    wire [N_MAP-1:0] segment_driver_map = segmap_r;

    // ------------------------------------------------------------
    // Per-pin role steering
    // ------------------------------------------------------------
    // Each shared pin is decided alone, so a wider map only widens
    // the loop and never the decode above it
    for (genvar p = 0; p < N_MAP; p++) begin : g_pin
        assign pin_lcd_mode[p]  = segment_driver_map[p];
        // Pins outside the map never see the all-common setting
        assign pin_as_common[p] = all_common_select &
                                  segment_driver_map[p];
        assign pin_force_gnd[p] = ~display_enable &
                                  segment_driver_map[p];
    end

    // Bit index is the common line number
    assign blink23 = blink23_r[LSB_BLINK +: BLINK_W];
    assign blink22 = supply22_r[LSB_BLINK +: BLINK_W];

    // The DAC is linear from the base to twice the base over the code
    assign analog.contrast_code =
        contrast_r[LSB_CONTRAST +: CONTRAST_W];
    assign analog.supply_from_battery = supply22_r[BIT_BATTERY];
    assign analog.bias_ground = ~display_enable;
    assign analog.frame_clock_select = main_r[LSB_CLKSEL +: CLKSEL_W];
    assign analog.bias_mode = main_r[LSB_MODE +: MODE_W];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    allcom_gate_a: assert property (@(posedge clk) disable iff (rst)
        (pin_as_common & ~pin_lcd_mode) == '0)
        else $error("Common role on unmapped pin");

    battery_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_supply22 |=> analog.supply_from_battery ==
            $past(req.wdata[BIT_BATTERY]))
        else $error("Battery select not taken from write");

    blink_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_blink23 |=> blink23 == $past(req.wdata[5:0]))
        else $error("Pin 23 blink map not written");

    blink_order_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_supply22 |=> blink22[5] == $past(req.wdata[5]) &&
            blink22[0] == $past(req.wdata[0]))
        else $error("Blink map bit order wrong");

    contrast_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_contrast) |=> $stable(analog.contrast_code))
        else $error("Contrast code changed without write");

    disable_gnd_a: assert property (@(posedge clk) disable iff (rst)
        !display_enable |-> analog.bias_ground &&
            pin_force_gnd == segment_driver_map)
        else $error("Disabled display not grounded");

    enable_free_a: assert property (@(posedge clk) disable iff (rst)
        display_enable |-> !analog.bias_ground && pin_force_gnd == '0)
        else $error("Enabled display held at ground");

    map_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_segmap |=> pin_lcd_mode == $past(req.wdata))
        else $error("Segment map not written");

    read_back_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_contrast ##1 req.rd && sel_contrast && !req.wr |=>
            rdata == ($past(req.wdata, 2) & MASK_CONTRAST))
        else $error("Contrast readback mismatch");

    read_idle_a: assert property (@(posedge clk) disable iff (rst)
        !req.rd |=> rdata == RST_BYTE)
        else $error("Read data not zero outside read");

    // ------------------------------------------------------------
    // Write capture per register
    // ------------------------------------------------------------
    // Masked bits must never store, or a later read shows junk
    main_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_main |=>
            main_r == ($past(req.wdata) & MASK_MAIN))
        else $error("Main register write lost");

    blink22_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_supply22 |=>
            blink22 == $past(req.wdata[LSB_BLINK +: BLINK_W]))
        else $error("Pin 22 blink map not written");

    contrast_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_contrast |=>
            analog.contrast_code == $past(req.wdata[CONTRAST_W-1:0]))
        else $error("Contrast code not written");

    enable_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_main |=>
            display_enable == $past(req.wdata[BIT_ENABLE]))
        else $error("Display enable not written");

    clk_sel_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_main |=> analog.frame_clock_select ==
            $past(req.wdata[LSB_CLKSEL +: CLKSEL_W]))
        else $error("Frame clock select not written");

    mode_write_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_main |=>
            analog.bias_mode == $past(req.wdata[LSB_MODE +: MODE_W]))
        else $error("Bias mode not written");

    blink23_order_a: assert property (@(posedge clk) disable iff (rst)
        req.wr && sel_blink23 |=> blink23[5] == $past(req.wdata[5]) &&
            blink23[0] == $past(req.wdata[0]))
        else $error("Pin 23 blink bit order wrong");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        (main_r & ~MASK_MAIN) == '0 && (blink23_r & ~MASK_BLINK) == '0 &&
            (supply22_r & ~MASK_SUPPLY) == '0)
        else $error("Unused register bit stored");

    // ------------------------------------------------------------
    // Fields hold without a write
    // ------------------------------------------------------------
    // A decode slip on a neighbour address would show up here first
    main_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_main) |=>
            $stable(main_r))
        else $error("Main register changed without write");

    blink23_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_blink23) |=>
            $stable(blink23_r))
        else $error("Pin 23 blink map changed without write");

    supply_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_supply22) |=>
            $stable(supply22_r))
        else $error("Supply register changed without write");

    segmap_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_segmap) |=>
            $stable(segmap_r))
        else $error("Segment map changed without write");

    battery_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(req.wr && sel_supply22) |=>
            $stable(analog.supply_from_battery))
        else $error("Battery select changed without write");

    // ------------------------------------------------------------
    // Read path and pin roles
    // ------------------------------------------------------------
    // Read data are the stored value as it stood at the strobe edge
    rd_main_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && sel_main |=>
            rdata == $past(main_r))
        else $error("Main register readback wrong");

    rd_blink23_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && sel_blink23 |=>
            rdata == $past(blink23_r))
        else $error("Pin 23 blink readback wrong");

    rd_supply_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && sel_supply22 |=>
            rdata == $past(supply22_r))
        else $error("Supply register readback wrong");

    rd_segmap_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && sel_segmap |=>
            rdata == $past(segmap_r))
        else $error("Segment map readback wrong");

    rd_contrast_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && sel_contrast |=>
            rdata == $past(contrast_r))
        else $error("Contrast readback wrong");

    // Unmapped addresses must not echo any neighbour's contents
    rd_hole_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && !(sel_main || sel_blink23 || sel_supply22 ||
            sel_segmap || sel_contrast) |=> rdata == RST_BYTE)
        else $error("Unmapped address read not zero");

    allcom_off_a: assert property (@(posedge clk) disable iff (rst)
        !all_common_select |->
            pin_as_common == '0)
        else $error("Common role without all-common select");

    allcom_on_a: assert property (@(posedge clk) disable iff (rst)
        all_common_select |->
            pin_as_common == segment_driver_map)
        else $error("Mapped pin not turned into common");

    gnd_mapped_a: assert property (@(posedge clk) disable iff (rst)
        (pin_force_gnd & ~pin_lcd_mode) == '0 &&
            (display_enable || pin_force_gnd == pin_lcd_mode))
        else $error("Ground forced on wrong pins");

endmodule : ldc_lcd_driver_control

// ===== ldc_panel_model.sv
// Behavioural LCD glass: shows which shared pins carry live segments.
// Assumes the pin-role outputs of the LCD driver control block.
`timescale 1ns/1ps
module ldc_panel_model (
    input  wire logic [7:0] pin_lcd_mode,  // Pin in LCD role
    input  wire logic [7:0] pin_as_common, // Pin drives a common
    input  wire logic       bias_ground,   // Bias nodes grounded
    output logic      [7:0] seg_live       // Pin shows a live segment
);
    // Grounded bias leaves the glass dark whatever the map says
    assign seg_live = bias_ground ? 8'h00
                    : (pin_lcd_mode & ~pin_as_common);
endmodule : ldc_panel_model

// ===== ldc_lcd_driver_control_bench.sv
// Self-checking bench for the LCD driver control registers.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module ldc_lcd_driver_control_bench;
    import ldc_pkg::*;
    // ------------------------------------------------------------
    // Signals and shadow registers
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    ldc_req_t    req = '0;
    logic [7:0]  rdata, lcd_mode, as_com, force_gnd, live;
    ldc_analog_t analog;
    logic [5:0]  blink23, blink22;
    logic        rd_d = 1'b0;
    logic [7:0]  expq[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          seed = 56;
    // Index 5 is an unmapped hole between the mapped registers
    logic [15:0] adr[6] = '{OFS_MAIN, OFS_BLINK23, OFS_SUPPLY22,
                            OFS_SEGMAP, OFS_CONTRAST, 16'h2403};
    logic [7:0]  msk[6] = '{8'hFB, 8'h3F, 8'hBF, 8'hFF, 8'h1F, 8'h00};
    logic [7:0]  sh[6] = '{default: 8'h00};

    always #25 clk = ~clk;

    ldc_lcd_driver_control #(.N_MAP(8)) dut_u (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .analog(analog),
        .pin_lcd_mode(lcd_mode), .pin_as_common(as_com),
        .pin_force_gnd(force_gnd), .blink23(blink23), .blink22(blink22));

    ldc_panel_model panel_u (.pin_lcd_mode(lcd_mode), .pin_as_common(as_com),
        .bias_ground(analog.bias_ground), .seg_live(live));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // Strobes stay up across back-to-back calls; idle drops them
    task automatic wr(input int i, input logic [7:0] d);
        req <= '{addr: adr[i], wdata: d, wr: 1'b1, rd: 1'b0};
        sh[i] = d & msk[i];
        @(posedge clk);
    endtask : wr

    task automatic rd(input int i);
        req <= '{addr: adr[i], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        expq.push_back(sh[i]);
        @(posedge clk);
    endtask : rd

    task automatic idle;
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        @(posedge clk);
    endtask : idle

    task automatic chk_out;
        @(negedge clk);
        check(lcd_mode, sh[3]);
        check(as_com, sh[3] & {8{sh[0][3]}});
        check(force_gnd, sh[0][7] ? 8'h00 : sh[3]);
        check({7'h00, analog.bias_ground}, {7'h00, ~sh[0][7]});
        check({7'h00, analog.supply_from_battery}, {7'h00, sh[2][7]});
        check({2'h0, blink23}, sh[1]);
        check({2'h0, blink22}, sh[2] & 8'h3F);
        check({3'h0, analog.contrast_code}, sh[4]);
        check({1'b0, analog.bias_mode, 2'b00, analog.frame_clock_select},
              sh[0] & 8'h73);
        check(live, sh[0][7] ? (sh[3] & ~{8{sh[0][3]}}) : 8'h00);
    endtask : chk_out

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d && expq.size() > 0)
            check(rdata, expq.pop_front());
        rd_d <= req.rd && !rst;
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rd(i);
        idle;
        chk_out;
        wr(3, 8'hA5);
        wr(0, 8'h08);
        idle;
        chk_out;
        repeat (24) begin
            for (int i = 0; i < 6; i++) begin
                wr(i, 8'($random(seed)));
                rd(i);
            end
            idle;
            chk_out;
        end
        // Reset in mid-run must clear every field again
        rst <= 1'b1;
        sh = '{default: 8'h00};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rd(i);
        idle;
        chk_out;
        results;
    end

    initial begin
        #100000;
        bad_count++;
        results;
    end
endmodule : ldc_lcd_driver_control_bench
